/* logic/vh_pkg.sv */
package vh_pkg;
  // object indices as seen by the network master
  localparam logic [15:0] CW_INDEX = 16'h6040;
  localparam logic [15:0] SW_INDEX = 16'h6041;
  // control word fields
  localparam int CW_HALT = 8;
  localparam int CW_HSTART = 4;
  localparam int CW_TYPE_LO = 12;
  localparam logic [1:0] TYPE_TORQUE = 2'h3;
  localparam logic [15:0] CW_RESET = 16'h0000;
  // status word fields
  localparam int SW_TLC = 15;
  localparam int SW_HERR = 13;
  localparam int SW_SPEED = 12;
  localparam int SW_ILIM = 11;
  localparam int SW_TREACH = 10;
  localparam int SW_REMOTE = 9;
  localparam int SW_WARN = 7;
  localparam logic [15:0] SW_RESET = 16'h0000;
  // operation modes on op_mode
  localparam logic [2:0] MODE_VEL = 3'h3;
  localparam logic [2:0] MODE_HOME = 3'h6;
  // speed judgment modes
  localparam logic [1:0] VA_CMD_EXACT = 2'h0;
  localparam logic [1:0] VA_CMD_BAND = 2'h1;
  localparam logic [1:0] VA_FB_BAND = 2'h2;
  // homing status codes {error, attained, target reached}
  localparam logic [2:0] HC_RUN = 3'h0;
  localparam logic [2:0] HC_IDLE = 3'h1;
  localparam logic [2:0] HC_DONE = 3'h3;
  localparam logic [2:0] HC_ALARM = 3'h5;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_RUN = 2'b01,
    H_DECEL = 2'b10
  } home_st_t;
endpackage

/* logic/speed_if.sv */
`timescale 1ns/10ps
interface speed_if #(parameter int W = 32);
  logic signed [W-1:0] cmd;
  logic signed [W-1:0] fb;
  logic signed [W-1:0] target;
  logic [W-1:0] band;
  logic [1:0] mode;
  logic attained;
  modport judge (input cmd, input fb, input target, input band, input mode, output attained);
  modport user (output cmd, output fb, output target, output band, output mode, input attained);
endinterface

/* logic/speed_judge.sv */
`timescale 1ns/10ps
module speed_judge #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic resetn,
  speed_if.judge sp
);
  typedef struct packed {
    logic att;
  } st_t;
  st_t q;
  st_t d;
  logic signed [W:0] dc;
  logic signed [W:0] df;
  logic [W:0] ac;
  logic [W:0] af;

  always_comb begin
    dc = {sp.cmd[W-1], sp.cmd} - {sp.target[W-1], sp.target};
    df = {sp.fb[W-1], sp.fb} - {sp.target[W-1], sp.target};
    ac = dc[W] ? $unsigned(-dc) : $unsigned(dc);
    af = df[W] ? $unsigned(-df) : $unsigned(df);
    d = q;
    case (sp.mode)
      vh_pkg::VA_CMD_EXACT: d.att = (dc == '0);
      vh_pkg::VA_CMD_BAND: d.att = (ac <= {1'b0, sp.band});
      vh_pkg::VA_FB_BAND: d.att = (af <= {1'b0, sp.band});
      default: d.att = (dc == '0);
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sp.attained = q.att;
endmodule // speed_judge

/* logic/vel_home_status.sv */
`timescale 1ns/10ps
// What this block does
// [R01] velocity mode, halt 0: target reached low until command speed reaches target
// [R02] halt 1: target reached low while decelerating, high once command speed is zero
// [R03] halt 0: target reached follows speed attained output, mode and band configurable
// [R04] remote status bit goes high once initialization has finished
// [R05] warning bit follows information conditions, clears itself without acknowledge
// [R06] torque-control type starts motor at target velocity with no ramp
// [R07] homing generates its own profile, presets position to home offset when done
// [R08] homing: halt 1 stops using the halt option code, 0 allows operation
// [R09] homing starts on a low-to-high edge of the homing start bit
// [R10] homing start returned to 0 during homing decelerates motor to stop
// [R11] start ignored while running, halted, stop input on, not enabled, de-excited
// [R12] factory state uses the sensor parameter set ahead of driver parameters
// [R13] master copies parameters, sets manual setting and method, saves, cycles power; block only samples manual_setting once after reset release
// [R14] homing status bits 13,12,10: 000 run, 001 idle, 011 done, 101 alarm
// [R15] start edge found by comparing written bit with previously stored bit
module vel_home_status #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cw_wr,
  input wire logic [15:0] cw_wdata,
  input wire logic [2:0] op_mode,
  input wire logic signed [W-1:0] cmd_speed,
  input wire logic signed [W-1:0] fb_speed,
  input wire logic signed [W-1:0] target_velocity,
  input wire logic [1:0] va_mode,
  input wire logic [W-1:0] va_band,
  input wire logic init_done,
  input wire logic info_active,
  input wire logic torque_limit,
  input wire logic internal_limit,
  input wire logic [6:0] dsm_bits,
  input wire logic op_enabled,
  input wire logic excited,
  input wire logic stop_in,
  input wire logic alarm,
  input wire logic homing_done,
  input wire logic [1:0] halt_option,
  input wire logic signed [W-1:0] home_offset,
  input wire logic manual_setting,
  output logic [15:0] cw_q,
  output logic [15:0] sw_q,
  output logic ramp_bypass_q,
  output logic home_run_q,
  output logic home_decel_q,
  output logic halt_stop_q,
  output logic [1:0] halt_mode_q,
  output logic preset_q,
  output logic signed [W-1:0] preset_pos_q,
  output logic sensor_params_q
);
  typedef struct packed {
    logic [15:0] cw;
    logic [15:0] sw;
    logic [1:0] stop_sync;
    vh_pkg::home_st_t hs;
    logic run;
    logic decel;
    logic [2:0] hcode;
    logic bypass;
    logic halt_stop;
    logic [1:0] halt_mode;
    logic preset;
    logic signed [W-1:0] preset_pos;
    logic sensor_params;
    logic strap_taken;
  } st_t;
  st_t q;
  st_t d;
  logic vel;
  logic hm;
  logic halt;
  logic rise;
  logic start_ok;
  logic spd_zero;
  logic treach;
  logic stop_s;

  speed_if #(.W(W)) sp ();
  assign sp.cmd = cmd_speed;
  assign sp.fb = fb_speed;
  assign sp.target = target_velocity;
  assign sp.band = va_band;
  assign sp.mode = va_mode;

  speed_judge #(.W(W)) u_judge (
    .clk(clk),
    .resetn(resetn),
    .sp(sp)
  );

  always_comb begin
    d = q;
    vel = (op_mode == vh_pkg::MODE_VEL);
    hm = (op_mode == vh_pkg::MODE_HOME);
    halt = q.cw[vh_pkg::CW_HALT];
    spd_zero = (cmd_speed == '0);
    stop_s = q.stop_sync[1];
    // only the second stage is read; the first may be metastable
    d.stop_sync = {q.stop_sync[0], stop_in};
    if (cw_wr) begin
      d.cw = cw_wdata;
    end
    rise = cw_wr && cw_wdata[vh_pkg::CW_HSTART] && !q.cw[vh_pkg::CW_HSTART]; // R15 R09
    start_ok = rise && hm && (q.hs == vh_pkg::H_IDLE) && !halt && !cw_wdata[vh_pkg::CW_HALT]
               && !stop_s && op_enabled && excited; // R11
    d.preset = 1'b0;
    d.halt_stop = hm && d.cw[vh_pkg::CW_HALT]; // R08
    d.halt_mode = halt_option; // R08
    d.bypass = vel && (q.cw[vh_pkg::CW_TYPE_LO+1:vh_pkg::CW_TYPE_LO] == vh_pkg::TYPE_TORQUE); // R06
    // sampled once after release so the strap never feeds the async reset
    if (!q.strap_taken) begin
      d.strap_taken = 1'b1;
      d.sensor_params = !manual_setting; // R12
    end
    case (q.hs)
      vh_pkg::H_IDLE: begin
        if (start_ok) begin
          d.hs = vh_pkg::H_RUN; // R09
          d.hcode = vh_pkg::HC_RUN;
        end
      end
      vh_pkg::H_RUN: begin
        if (alarm) begin
          d.hs = vh_pkg::H_IDLE;
          d.hcode = vh_pkg::HC_ALARM; // R14
        end else if (homing_done) begin
          d.hs = vh_pkg::H_IDLE;
          d.hcode = vh_pkg::HC_DONE; // R14
          d.preset = 1'b1; // R07
          d.preset_pos = home_offset; // R07
        end else if (!hm || !d.cw[vh_pkg::CW_HSTART] || d.cw[vh_pkg::CW_HALT] || stop_s) begin
          d.hs = vh_pkg::H_DECEL; // R10
        end
      end
      vh_pkg::H_DECEL: begin
        if (alarm) begin
          d.hs = vh_pkg::H_IDLE;
          d.hcode = vh_pkg::HC_ALARM;
        end else if (spd_zero) begin
          d.hs = vh_pkg::H_IDLE;
          d.hcode = vh_pkg::HC_IDLE;
        end
      end
      default: d.hs = vh_pkg::H_IDLE;
    endcase
    // state decoded ahead of the register so both outputs come straight from flops
    d.run = (d.hs == vh_pkg::H_RUN);
    d.decel = (d.hs == vh_pkg::H_DECEL);
    // halt 1 reports stop completion, halt 0 reports the attained judgment
    treach = halt ? spd_zero : sp.attained; // R01 R02 R03
    d.sw = '0;
    d.sw[6:0] = dsm_bits;
    d.sw[vh_pkg::SW_WARN] = info_active; // R05
    d.sw[vh_pkg::SW_REMOTE] = init_done; // R04
    d.sw[vh_pkg::SW_ILIM] = internal_limit;
    d.sw[vh_pkg::SW_TLC] = torque_limit;
    if (vel) begin
      d.sw[vh_pkg::SW_TREACH] = treach;
      d.sw[vh_pkg::SW_SPEED] = spd_zero;
    end else if (hm) begin
      d.sw[vh_pkg::SW_HERR] = q.hcode[2]; // R14
      d.sw[vh_pkg::SW_SPEED] = q.hcode[1];
      d.sw[vh_pkg::SW_TREACH] = q.hcode[0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.cw <= vh_pkg::CW_RESET;
      q.sw <= vh_pkg::SW_RESET;
      q.hs <= vh_pkg::H_IDLE;
      q.hcode <= vh_pkg::HC_IDLE;
      q.sensor_params <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign cw_q = q.cw;
  assign sw_q = q.sw;
  assign ramp_bypass_q = q.bypass;
  assign home_run_q = q.run;
  assign home_decel_q = q.decel;
  assign halt_stop_q = q.halt_stop;
  assign halt_mode_q = q.halt_mode;
  assign preset_q = q.preset;
  assign preset_pos_q = q.preset_pos;
  assign sensor_params_q = q.sensor_params;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_tr_low;
    (vel && !halt && !sp.attained) |=> !sw_q[vh_pkg::SW_TREACH];
  endproperty
  a_tr_low: assert property (p_tr_low) else $error("target reached set before speed attained"); // R01
  property p_tr_decel;
    (vel && halt && !spd_zero) |=> !sw_q[vh_pkg::SW_TREACH];
  endproperty
  a_tr_decel: assert property (p_tr_decel) else $error("target reached set while decelerating"); // R02
  property p_tr_stop;
    (vel && halt && spd_zero) |=> sw_q[vh_pkg::SW_TREACH];
  endproperty
  a_tr_stop: assert property (p_tr_stop) else $error("target reached missing at zero speed"); // R02
  property p_tr_va;
    (vel && !halt) |=> (sw_q[vh_pkg::SW_TREACH] == $past(sp.attained));
  endproperty
  a_tr_va: assert property (p_tr_va) else $error("target reached not following attained"); // R03
  property p_remote;
    init_done |=> sw_q[vh_pkg::SW_REMOTE];
  endproperty
  a_remote: assert property (p_remote) else $error("remote bit not set after init"); // R04
  property p_warn;
    1'b1 |=> (sw_q[vh_pkg::SW_WARN] == $past(info_active));
  endproperty
  a_warn: assert property (p_warn) else $error("warning bit not tracking information"); // R05
  property p_bypass;
    (vel && q.cw[13:12] == vh_pkg::TYPE_TORQUE) |=> ramp_bypass_q;
  endproperty
  a_bypass: assert property (p_bypass) else $error("torque type did not bypass ramp"); // R06
  property p_preset;
    (home_run_q && !alarm && homing_done) |=> (preset_q && preset_pos_q == $past(home_offset));
  endproperty
  a_preset: assert property (p_preset) else $error("home offset preset missing"); // R07
  property p_halt;
    (hm && cw_wr && cw_wdata[vh_pkg::CW_HALT]) |=> halt_stop_q;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not stop homing"); // R08
  property p_start;
    start_ok |=> home_run_q ##1 (sw_q[13:12] == 2'b00 && !sw_q[vh_pkg::SW_TREACH]) || !hm;
  endproperty
  a_start: assert property (p_start) else $error("homing start edge not taken"); // R09
  property p_abort;
    (home_run_q && cw_wr && !cw_wdata[vh_pkg::CW_HSTART] && !alarm && !homing_done) |=> home_decel_q;
  endproperty
  a_abort: assert property (p_abort) else $error("start bit cleared without deceleration"); // R10
  property p_refuse;
    (rise && (stop_s || !op_enabled || !excited || halt)) |=> !home_run_q || $past(home_run_q);
  endproperty
  a_refuse: assert property (p_refuse) else $error("blocked homing start accepted"); // R11
  c_home_done: cover property (home_run_q ##[1:20] preset_q);
  c_home_abort: cover property (home_decel_q ##[1:20] !home_decel_q);
  c_vel_reach: cover property (vel && !halt ##1 sw_q[vh_pkg::SW_TREACH]);
endmodule // vel_home_status

/* sim/fb_master.sv */
`timescale 1ns/10ps
module fb_master (
  input wire logic clk,
  output logic cw_wr,
  output logic [15:0] cw_wdata,
  output logic manual_setting
);
  initial begin
    cw_wr = 1'b0;
    cw_wdata = 16'h0000;
    manual_setting = 1'b1;
  end
  // one write per call; strobe stays up so back-to-back writes never touch it twice in one step
  task automatic write(input logic [15:0] d);
    cw_wr = 1'b1;
    cw_wdata = d;
    @(posedge clk);
    #1;
  endtask
  // ends a run of writes after its last taking edge
  task automatic idle();
    if (cw_wr) begin
      cw_wr = 1'b0;
      cw_wdata = ~cw_wdata; // stale data would hide a late capture
    end
  endtask
  task automatic strap(input logic v);
    manual_setting = v;
  endtask
endmodule // fb_master

/* sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  localparam int W = 32;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cw_wr, manual_setting, init_done, info_active, torque_limit, internal_limit;
  logic op_enabled, excited, stop_in, alarm, homing_done;
  logic [15:0] cw_wdata, cw_q, sw_q;
  logic [2:0] op_mode;
  logic signed [W-1:0] cmd_speed, fb_speed, target_velocity, home_offset, preset_pos_q;
  logic [W-1:0] va_band;
  logic [1:0] va_mode, halt_option, halt_mode_q;
  logic [6:0] dsm_bits;
  logic ramp_bypass_q, home_run_q, home_decel_q, halt_stop_q, preset_q, sensor_params_q;
  int num_errors = 0;
  int num_checks = 0;
  int seed = 32'h1bbd;
  logic [31:0] d;
  always #4 clk = ~clk;
  fb_master u_fb_master (.clk(clk), .cw_wr(cw_wr), .cw_wdata(cw_wdata), .manual_setting(manual_setting));
  vel_home_status #(.W(W)) u_vel_home_status (.clk(clk), .resetn(resetn), .cw_wr(cw_wr), .cw_wdata(cw_wdata),
    .op_mode(op_mode), .cmd_speed(cmd_speed), .fb_speed(fb_speed), .target_velocity(target_velocity),
    .va_mode(va_mode), .va_band(va_band), .init_done(init_done), .info_active(info_active),
    .torque_limit(torque_limit), .internal_limit(internal_limit), .dsm_bits(dsm_bits),
    .op_enabled(op_enabled), .excited(excited), .stop_in(stop_in), .alarm(alarm), .homing_done(homing_done),
    .halt_option(halt_option), .home_offset(home_offset), .manual_setting(manual_setting), .cw_q(cw_q),
    .sw_q(sw_q), .ramp_bypass_q(ramp_bypass_q), .home_run_q(home_run_q), .home_decel_q(home_decel_q),
    .halt_stop_q(halt_stop_q), .halt_mode_q(halt_mode_q), .preset_q(preset_q), .preset_pos_q(preset_pos_q),
    .sensor_params_q(sensor_params_q));
  task automatic tick(input int n);
    u_fb_master.idle();
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [W-1:0] seen, input logic [W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] base_sw(input logic [2:0] c);
    return {torque_limit, 1'b0, c[2], c[1], internal_limit, c[0], init_done, 1'b0, info_active, dsm_bits};
  endfunction
  // velocity view: code bits carry {0, zero speed, target reached}
  function automatic logic [15:0] vel_sw(input logic halt);
    logic [W-1:0] dc, df;
    logic att;
    dc = cmd_speed - target_velocity;
    df = fb_speed - target_velocity;
    if (dc[W-1]) dc = -dc;
    if (df[W-1]) df = -df;
    case (va_mode)
      2'h1: att = (dc <= va_band);
      2'h2: att = (df <= va_band);
      default: att = (cmd_speed == target_velocity);
    endcase
    return base_sw({1'b0, cmd_speed == 0, halt ? cmd_speed == 0 : att});
  endfunction
  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {op_mode, cmd_speed, fb_speed, target_velocity, va_mode, va_band, init_done, info_active} = '0;
    {torque_limit, internal_limit, dsm_bits, stop_in, alarm, homing_done, halt_option, home_offset} = '0;
    op_enabled = 1'b1;
    excited = 1'b1;
    tick(2);
    chk(sw_q, 16'h0000);
    resetn = 1'b1;
    tick(1);
    chk(sensor_params_q, 1'b0);
    op_mode = vh_pkg::MODE_VEL;
    for (int i = 0; i < 60; i++) begin
      d = $random(seed);
      cmd_speed = $random(seed) % 3;
      target_velocity = (i < 4) ? cmd_speed : $random(seed) % 3;
      fb_speed = $random(seed) % 3;
      {dsm_bits, internal_limit, torque_limit, info_active, init_done, va_mode} = d[12:0];
      va_band = {30'h0, d[16:15]};
      u_fb_master.write({2'b00, d[18:17], 3'b000, d[19], 8'h00});
      tick(2);
      chk(sw_q, vel_sw(d[19]));
      chk(ramp_bypass_q, d[18:17] == vh_pkg::TYPE_TORQUE);
    end
    $display("velocity status test done");
    op_mode = vh_pkg::MODE_HOME;
    halt_option = d[21:20];
    home_offset = $random(seed);
    cmd_speed = 5;
    // last velocity word may have left halt set, which would refuse the start
    u_fb_master.write(16'h0000);
    u_fb_master.write(16'h0010);
    chk(home_run_q, 1'b1);
    tick(1);
    chk(sw_q, base_sw(vh_pkg::HC_RUN));
    homing_done = 1'b1;
    tick(1);
    chk(preset_q, 1'b1);
    chk(preset_pos_q, home_offset);
    homing_done = 1'b0;
    tick(1);
    chk(sw_q, base_sw(vh_pkg::HC_DONE));
    chk(preset_q, 1'b0);
    u_fb_master.write(16'h0010);
    chk(home_run_q, 1'b0);
    for (int j = 0; j < 4; j++) begin
      excited = (j != 0);
      op_enabled = (j != 1);
      stop_in = (j == 2);
      u_fb_master.write(16'h0000);
      tick(2);
      u_fb_master.write((j == 3) ? 16'h0110 : 16'h0010);
      tick(1);
      chk(home_run_q, 1'b0);
    end
    {excited, op_enabled, stop_in} = 3'b110;
    u_fb_master.write(16'h0000);
    tick(2);
    u_fb_master.write(16'h0010);
    u_fb_master.write(16'h0000);
    tick(1);
    chk(home_decel_q, 1'b1);
    cmd_speed = 0;
    tick(2);
    chk(sw_q, base_sw(vh_pkg::HC_IDLE));
    for (int k = 0; k < 24; k++) begin
      d = $random(seed);
      {excited, op_enabled, stop_in} = d[2:0];
      u_fb_master.write(16'h0000);
      // three edges: a run started above returns to idle and stop_in passes the synchroniser
      tick(3);
      u_fb_master.write({7'h00, d[3], 8'h10});
      tick(1);
      chk(home_run_q, d[2] && d[1] && !d[0] && !d[3]);
    end
    $display("random start test done");
    {excited, op_enabled, stop_in} = 3'b110;
    u_fb_master.write(16'h0000);
    tick(3);
    cmd_speed = 5;
    u_fb_master.write(16'h0010);
    u_fb_master.write(16'h0110);
    chk(halt_stop_q, 1'b1);
    chk(halt_mode_q, halt_option);
    tick(1);
    chk(home_decel_q, 1'b1);
    alarm = 1'b1;
    tick(2);
    chk(sw_q, base_sw(vh_pkg::HC_ALARM));
    alarm = 1'b0;
    $display("homing test done");
    // any other mode shows no homing code and drops the halt stop
    op_mode = 3'h1;
    tick(2);
    chk(sw_q, base_sw(3'h0));
    chk(halt_stop_q, 1'b0);
    // second reset with the strap turned off the manual side, to the factory state
    resetn = 1'b0;
    u_fb_master.strap(1'b0);
    tick(1);
    chk(sensor_params_q, 1'b1);
    chk(sw_q, 16'h0000);
    resetn = 1'b1;
    tick(1);
    chk(sensor_params_q, 1'b1);
    chk(sw_q, base_sw(3'h0));
    $display("reset test done");
    results();
  end
  // whole run is under a thousand cycles; this limit allows ample margin
  initial begin
    #100000;
    num_errors++;
    results();
  end
endmodule // tb_top
